// file: core/grlc_pkg.sv
package grlc_pkg;
    // bus command bytes, taken while attention is true
    localparam logic [7:0] CMD_GTL = 8'h01;
    localparam logic [7:0] CMD_SDC = 8'h04;
    localparam logic [7:0] CMD_LLO = 8'h11;
    localparam logic [7:0] CMD_DCL = 8'h14;
    localparam logic [7:0] CMD_UNL = 8'h3F;
    localparam logic [7:0] CMD_UNT = 8'h5F;
    // listen and talk address groups: top three bits select, low five
    // bits carry the primary address
    localparam logic [2:0] GRP_LISTEN = 3'h1;
    localparam logic [2:0] GRP_TALK = 3'h2;
    localparam int ADDR_W = 5;
    localparam int ADDR_LSB = 0;
    localparam int GRP_LSB = 5;
    localparam logic [4:0] ADDR_DEF = 5'h09;
    // front panel key vector width, local key is separate
    localparam int KEY_W = 16;
    // bus pins passed through the synchroniser: ren, ifc, atn, dav, dio
    localparam int PIN_W = 12;
    localparam int PIN_REN = 11;
    localparam int PIN_IFC = 10;
    localparam int PIN_ATN = 9;
    localparam int PIN_DAV = 8;
    // factory defaults; rate counted in tenths of a microsecond
    localparam logic [3:0] FUNC_DEF = 4'h1;
    localparam logic [3:0] RANGE_DEF = 4'h0;
    localparam logic [23:0] RATE_DEF = 24'h000683;
    localparam logic [15:0] SAMPLES_DEF = 16'h0065;
    localparam logic [15:0] DELAY_DEF = 16'h0000;
    localparam logic [2:0] TRIG_DEF = 3'h6;
    localparam logic [2:0] FORMAT_DEF = 3'h2;
    localparam logic [1:0] CHANNEL_DEF = 2'h1;
    localparam logic [7:0] TERM_FIRST_DEF = 8'h0D;
    localparam logic [7:0] TERM_SECOND_DEF = 8'h0A;
    // remote/local states, the high bit marks a remembered lockout
    typedef enum logic [1:0] {
        ST_LOCAL = 2'b00,
        ST_REMOTE = 2'b01,
        ST_LOCAL_LLO = 2'b10,
        ST_REMOTE_LLO = 2'b11
    } grlc_state_e;
endpackage

// file: core/grlc_sync.sv
// two flip-flop synchroniser, one chain per bit
module grlc_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // first stage feeds only the second stage
            always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    meta[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta[i] <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule

// file: core/grlc_ctrl.sv
module grlc_ctrl
    import grlc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic ren_in,
    input wire logic ifc_in,
    input wire logic atn_in,
    input wire logic dav_in,
    input wire logic [7:0] dio_in,
    input wire logic local_key_in,
    input wire logic panel_reset_in,
    input wire logic [KEY_W-1:0] panel_keys_in,
    input wire logic addr_set_in,
    input wire logic [ADDR_W-1:0] addr_value_in,
    input wire logic [3:0] setup_function_in,
    input wire logic [3:0] setup_range_in,
    input wire logic [23:0] setup_rate_in,
    input wire logic [15:0] setup_samples_in,
    input wire logic [15:0] setup_delay_in,
    input wire logic setup_filter_in,
    input wire logic setup_zero_in,
    input wire logic setup_ac_in,
    output logic [KEY_W-1:0] panel_keys_out,
    output logic remote_out,
    output logic lockout_out,
    output logic talk_out,
    output logic listen_out,
    output logic clear_out,
    output logic [ADDR_W-1:0] bus_addr_out,
    output logic [3:0] cfg_function_out,
    output logic [3:0] cfg_range_out,
    output logic [23:0] cfg_rate_out,
    output logic [15:0] cfg_samples_out,
    output logic [15:0] cfg_delay_out,
    output logic cfg_filter_out,
    output logic cfg_zero_out,
    output logic cfg_ac_out,
    output logic [2:0] cfg_trigger_out,
    output logic [2:0] cfg_format_out,
    output logic [1:0] cfg_channel_out,
    output logic cfg_analog_en_out,
    output logic cfg_buffer_en_out,
    output logic cfg_srq_en_out,
    output logic cfg_eoi_holdoff_out,
    output logic [15:0] cfg_terminator_out
);
    logic [PIN_W-1:0] pins_s;
    logic ren_s;
    logic ifc_s;
    logic atn_s;
    logic dav_s;
    logic dav_q;
    logic [7:0] dio_s;
    logic cmd_take;
    logic mla_hit;
    logic mta_hit;
    logic gtl_hit;
    logic llo_hit;
    logic clear_hit;
    logic load_pend;
    logic addr_set_ok;
    grlc_state_e state;
    grlc_state_e next_state;

    // bus pins are asynchronous to the core clock
    grlc_sync #(
        .W(PIN_W)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .async_in({ren_in, ifc_in, atn_in, dav_in, dio_in}),
        .sync_out(pins_s)
    );

    assign ren_s = pins_s[PIN_REN];
    assign ifc_s = pins_s[PIN_IFC];
    assign atn_s = pins_s[PIN_ATN];
    assign dav_s = pins_s[PIN_DAV];
    assign dio_s = pins_s[7:0];

    // data valid edge; the bus settles data before dav, so the synced
    // byte is already stable when the edge shows
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dav_q <= 1'b0;
        end else begin
            dav_q <= dav_s;
        end
    end

    // command decode under attention; IFC blocks all decode
    assign cmd_take = dav_s && !dav_q && atn_s && !ifc_s;
    assign mla_hit = cmd_take && dio_s[7:GRP_LSB] == GRP_LISTEN
        && dio_s[ADDR_LSB +: ADDR_W] == bus_addr_out;
    assign mta_hit = cmd_take && dio_s[7:GRP_LSB] == GRP_TALK
        && dio_s[ADDR_LSB +: ADDR_W] == bus_addr_out;
    // universal commands ignore addressing, addressed ones need listen
    assign llo_hit = cmd_take && dio_s == CMD_LLO;
    assign gtl_hit = cmd_take && dio_s == CMD_GTL && listen_out;
    assign clear_hit = (cmd_take && dio_s == CMD_DCL)
        || (cmd_take && dio_s == CMD_SDC && listen_out)
        || (panel_reset_in && !remote_out);

    // talker and listener addressing; interface clear wins over all
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            talk_out <= 1'b0;
            listen_out <= 1'b0;
        end else if (ifc_s) begin
            talk_out <= 1'b0;
            listen_out <= 1'b0;
        end else if (mla_hit) begin
            talk_out <= 1'b0;
            listen_out <= 1'b1;
        end else if (mta_hit) begin
            talk_out <= 1'b1;
            listen_out <= 1'b0;
        end else if (cmd_take && dio_s == CMD_UNL) begin
            listen_out <= 1'b0;
        end else if (cmd_take && dio_s == CMD_UNT) begin
            talk_out <= 1'b0;
        end
    end

    // remote/local sequencing; losing REN dominates everything else
    always_comb begin
        next_state = state;
        if (!ren_s) begin
            next_state = ST_LOCAL;
        end else begin
            unique case (state)
                ST_LOCAL: begin
                    if (mla_hit) begin
                        next_state = ST_REMOTE;
                    end else if (llo_hit) begin
                        next_state = ST_LOCAL_LLO;
                    end
                end
                ST_LOCAL_LLO: begin
                    if (mla_hit) begin
                        next_state = ST_REMOTE_LLO;
                    end
                end
                ST_REMOTE: begin
                    if (llo_hit) begin
                        next_state = ST_REMOTE_LLO;
                    end else if (gtl_hit || local_key_in) begin
                        next_state = ST_LOCAL;
                    end
                end
                ST_REMOTE_LLO: begin
                    // local key has no effect here; go to local keeps the
                    // lockout pending so only REN can cancel it
                    if (gtl_hit) begin
                        next_state = ST_LOCAL_LLO;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= ST_LOCAL;
        end else begin
            state <= next_state;
        end
    end

    assign remote_out = state == ST_REMOTE || state == ST_REMOTE_LLO;
    assign lockout_out = state == ST_REMOTE_LLO;
    // keys pass only in local; power is outside this block
    assign panel_keys_out = remote_out ? '0 : panel_keys_in;

    // primary address: set from the panel in local only
    assign addr_set_ok = addr_set_in && !remote_out;
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bus_addr_out <= ADDR_DEF;
        end else if (addr_set_ok) begin
            bus_addr_out <= addr_value_in;
        end
    end

    // stored setup cannot be sampled under async reset, so it loads on
    // the first edge after release, exactly as a clear does
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            load_pend <= 1'b1;
            clear_out <= 1'b0;
        end else begin
            load_pend <= 1'b0;
            clear_out <= clear_hit;
        end
    end

    // configuration reload; primary address is not part of it
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cfg_function_out <= FUNC_DEF;
            cfg_range_out <= RANGE_DEF;
            cfg_rate_out <= RATE_DEF;
            cfg_samples_out <= SAMPLES_DEF;
            cfg_delay_out <= DELAY_DEF;
            cfg_filter_out <= 1'b0;
            cfg_zero_out <= 1'b0;
            cfg_ac_out <= 1'b0;
            cfg_trigger_out <= TRIG_DEF;
            cfg_format_out <= FORMAT_DEF;
            cfg_channel_out <= CHANNEL_DEF;
            cfg_analog_en_out <= 1'b0;
            cfg_buffer_en_out <= 1'b0;
            cfg_srq_en_out <= 1'b0;
            cfg_eoi_holdoff_out <= 1'b1;
            cfg_terminator_out <= {TERM_FIRST_DEF, TERM_SECOND_DEF};
        end else if (clear_hit || load_pend) begin
            cfg_function_out <= setup_function_in;
            cfg_range_out <= setup_range_in;
            cfg_rate_out <= setup_rate_in;
            cfg_samples_out <= setup_samples_in;
            cfg_delay_out <= setup_delay_in;
            cfg_filter_out <= setup_filter_in;
            cfg_zero_out <= setup_zero_in;
            cfg_ac_out <= setup_ac_in;
            cfg_trigger_out <= TRIG_DEF;
            cfg_format_out <= FORMAT_DEF;
            cfg_channel_out <= CHANNEL_DEF;
            cfg_analog_en_out <= 1'b0;
            cfg_buffer_en_out <= 1'b0;
            cfg_srq_en_out <= 1'b0;
            cfg_eoi_holdoff_out <= 1'b1;
            cfg_terminator_out <= {TERM_FIRST_DEF, TERM_SECOND_DEF};
        end
    end

    // checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    chk_remote_needs_listen: assert property (
        $rose(remote_out) |-> $past(mla_hit) && $past(ren_s))
        else $error("remote entered without listen address and REN");
    chk_keys_gated: assert property (
        remote_out |-> panel_keys_out == '0)
        else $error("panel key passed while in remote");
    chk_local_key: assert property (
        state == ST_REMOTE && local_key_in && ren_s && !llo_hit
        |=> state == ST_LOCAL)
        else $error("local key did not return to local");
    chk_ifc_idle: assert property (
        ifc_s |=> !talk_out && !listen_out)
        else $error("interface clear left talk or listen active");
    chk_lockout_holds: assert property (
        state == ST_REMOTE_LLO && local_key_in && ren_s && !gtl_hit
        |=> lockout_out && remote_out)
        else $error("local key broke through lockout");
    chk_pending_llo: assert property (
        state == ST_LOCAL_LLO && mla_hit && ren_s
        |=> remote_out && lockout_out)
        else $error("remembered lockout not applied on remote");
    chk_ren_cancel: assert property (
        !ren_s |=> state == ST_LOCAL && !lockout_out)
        else $error("lockout or remote survived REN false");
    chk_gtl_local: assert property (
        gtl_hit && ren_s |=> !remote_out)
        else $error("go to local left device in remote");
    chk_clear_reload: assert property (
        clear_hit |=> clear_out && cfg_rate_out == $past(setup_rate_in))
        else $error("clear did not reload stored setup");
    chk_addr_kept: assert property (
        clear_hit && !addr_set_ok |=> $stable(bus_addr_out))
        else $error("clear changed primary address");
    chk_clear_defaults: assert property (
        clear_out |-> cfg_channel_out == CHANNEL_DEF
        && cfg_terminator_out == {TERM_FIRST_DEF, TERM_SECOND_DEF}
        && !cfg_srq_en_out && cfg_eoi_holdoff_out)
        else $error("fixed defaults wrong after clear");
    chk_sdc_addressed: assert property (
        cmd_take && dio_s == CMD_SDC && !listen_out && !panel_reset_in
        |=> !clear_out)
        else $error("selective clear acted while unaddressed");

    cov_remote: cover property ($rose(remote_out));
    cov_lockout: cover property ($rose(lockout_out));
    cov_clear: cover property (clear_out && remote_out);
    cov_ifc: cover property (ifc_s && talk_out);
endmodule

// file: tb/grlc_ctl_model.sv
// behavioural bus controller facing the instrument
module grlc_ctl_model (
    input wire logic ref_clk_in,
    output logic ren_out,
    output logic ifc_out,
    output logic atn_out,
    output logic dav_out,
    output logic [7:0] dio_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // lines idle false; data idles at a value no byte uses
    initial begin
        ren_out = 1'b0;
        ifc_out = 1'b0;
        atn_out = 1'b0;
        dav_out = 1'b0;
        dio_out = 8'hFF;
    end
    // data settles two cycles before valid rises, so the synchroniser
    // never sees a half-changed byte
    task automatic put_byte(input logic [7:0] b);
        @(posedge ref_clk_in);
        atn_out <= 1'b1;
        dio_out <= b;
        repeat (2) @(posedge ref_clk_in);
        dav_out <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        dav_out <= 1'b0;
        dio_out <= ~b; // released data must not look like the last byte
        atn_out <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
    endtask
    // remote enable is changed alone, between bytes, with no other line moving
    task automatic set_ren(input logic v);
        @(posedge ref_clk_in);
        ren_out <= v;
        repeat (4) @(posedge ref_clk_in);
    endtask
    // interface clear held for the full minimum time in cycles
    task automatic pulse_ifc(input int n);
        @(posedge ref_clk_in);
        ifc_out <= 1'b1;
        repeat (n) @(posedge ref_clk_in);
        ifc_out <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
    endtask
endmodule

// file: tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import grlc_pkg::*;
    typedef struct packed {
        logic [7:0] b;
        logic rem;
        logic lock;
        logic lis;
        logic tlk;
    } grlc_row_s;
    localparam logic [7:0] MLA = {GRP_LISTEN, ADDR_DEF};
    localparam logic [7:0] MTA = {GRP_TALK, ADDR_DEF};
    logic ref_clk_in, rst_b_in, ren_in, ifc_in, atn_in, dav_in;
    logic [7:0] dio_in;
    logic local_key_in, panel_reset_in, addr_set_in;
    logic [KEY_W-1:0] panel_keys_in, panel_keys_out;
    logic [ADDR_W-1:0] addr_value_in, bus_addr_out;
    logic [3:0] setup_function_in, setup_range_in;
    logic [3:0] cfg_function_out, cfg_range_out;
    logic [23:0] setup_rate_in, cfg_rate_out;
    logic [15:0] setup_samples_in, setup_delay_in, cfg_samples_out;
    logic [15:0] cfg_delay_out, cfg_terminator_out;
    logic setup_filter_in, setup_zero_in, setup_ac_in;
    logic remote_out, lockout_out, talk_out, listen_out, clear_out;
    logic cfg_filter_out, cfg_zero_out, cfg_ac_out, cfg_analog_en_out;
    logic cfg_buffer_en_out, cfg_srq_en_out, cfg_eoi_holdoff_out;
    logic [2:0] cfg_trigger_out, cfg_format_out;
    logic [1:0] cfg_channel_out;
    int err_total = 0;
    int check_count = 0;
    int clr_seen = 0;
    grlc_row_s rows [8];
    grlc_ctl_model ctl (.ref_clk_in, .ren_out(ren_in), .ifc_out(ifc_in),
        .atn_out(atn_in), .dav_out(dav_in), .dio_out(dio_in));
    grlc_ctrl dut (.ref_clk_in, .rst_b_in, .ren_in, .ifc_in, .atn_in,
        .dav_in, .dio_in, .local_key_in, .panel_reset_in, .panel_keys_in,
        .addr_set_in, .addr_value_in, .setup_function_in, .setup_range_in,
        .setup_rate_in, .setup_samples_in, .setup_delay_in,
        .setup_filter_in, .setup_zero_in, .setup_ac_in, .panel_keys_out,
        .remote_out, .lockout_out, .talk_out, .listen_out, .clear_out,
        .bus_addr_out, .cfg_function_out, .cfg_range_out, .cfg_rate_out,
        .cfg_samples_out, .cfg_delay_out, .cfg_filter_out, .cfg_zero_out,
        .cfg_ac_out, .cfg_trigger_out, .cfg_format_out, .cfg_channel_out,
        .cfg_analog_en_out, .cfg_buffer_en_out, .cfg_srq_en_out,
        .cfg_eoi_holdoff_out, .cfg_terminator_out);
    // free running 40 MHz clock
    initial begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end
    // the clear pulse lasts one cycle, so count it as it passes
    always @(posedge ref_clk_in) begin
        if (clear_out === 1'b1) begin
            clr_seen <= clr_seen + 1;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // one local key press, held two cycles to clear the key logic
    task automatic press_local();
        @(posedge ref_clk_in);
        local_key_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        local_key_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
    endtask
    // one-cycle pulse on the panel reset and address set keys
    task automatic pulse_panel(input logic rst, input logic set);
        @(posedge ref_clk_in);
        panel_reset_in <= rst;
        addr_set_in <= set;
        @(posedge ref_clk_in);
        panel_reset_in <= 1'b0;
        addr_set_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
    endtask
    initial begin
        rst_b_in = 1'b0;
        local_key_in = 1'b0;
        panel_reset_in = 1'b0; // panel reset idles low until the panel test
        addr_set_in = 1'b0;
        addr_value_in = 5'h00;
        panel_keys_in = 16'hA5A5;
        setup_function_in = 4'h3;
        setup_range_in = 4'h2;
        setup_rate_in = 24'h000123;
        setup_samples_in = 16'h0010;
        setup_delay_in = 16'h0007;
        setup_filter_in = 1'b1;
        setup_zero_in = 1'b1;
        setup_ac_in = 1'b1;
        // ren is on for every row; lockout only matters while remote
        rows[0] = {MLA, 4'b1010};
        rows[1] = {MTA, 4'b1001};
        rows[2] = {CMD_UNT, 4'b1000};
        rows[3] = {CMD_LLO, 4'b1100};
        rows[4] = {MLA, 4'b1110};
        rows[5] = {CMD_GTL, 4'b0010};
        rows[6] = {MLA, 4'b1110};
        rows[7] = {CMD_UNL, 4'b1100};
        repeat (20) @(posedge ref_clk_in);
        // factory values stand while reset is held
        chk("function", FUNC_DEF, cfg_function_out);
        chk("rate", RATE_DEF, cfg_rate_out);
        chk("samples", SAMPLES_DEF, cfg_samples_out);
        chk("bus_addr", ADDR_DEF, bus_addr_out);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        chk("bus_addr", ADDR_DEF, bus_addr_out);
        chk("function", 4'h3, cfg_function_out);
        chk("rate", 24'h000123, cfg_rate_out);
        chk("delay", 16'h0007, cfg_delay_out);
        chk("range", 4'h2, cfg_range_out);
        chk("samples", 16'h0010, cfg_samples_out);
        chk("setup_bits", 3'h7, {cfg_filter_out, cfg_zero_out,
            cfg_ac_out});
        chk("trigger", TRIG_DEF, cfg_trigger_out);
        chk("off_bits", 3'h0, {cfg_analog_en_out, cfg_buffer_en_out,
            cfg_srq_en_out});
        chk("format", FORMAT_DEF, cfg_format_out);
        chk("channel", CHANNEL_DEF, cfg_channel_out);
        chk("eoi", 1'b1, cfg_eoi_holdoff_out);
        chk("term", {TERM_FIRST_DEF, TERM_SECOND_DEF},
            cfg_terminator_out);
        $display("test reset done");
        // addressed with ren false must stay local
        ctl.put_byte(MLA);
        chk("remote", 1'b0, remote_out);
        chk("keys", panel_keys_in, panel_keys_out);
        $display("test ren false done");
        ctl.set_ren(1'b1);
        chk("remote", 1'b0, remote_out);
        foreach (rows[i]) begin
            ctl.put_byte(rows[i].b);
            chk("remote", rows[i].rem, remote_out);
            if (rows[i].rem) begin
                chk("lockout", rows[i].lock, lockout_out);
            end
            chk("listen", rows[i].lis, listen_out);
            chk("talk", rows[i].tlk, talk_out);
        end
        $display("test rows done");
        press_local();
        chk("remote", 1'b1, remote_out);
        chk("keys", 16'h0000, panel_keys_out);
        ctl.set_ren(1'b0);
        ctl.set_ren(1'b1);
        ctl.put_byte(MLA);
        chk("lockout", 1'b0, lockout_out);
        press_local();
        chk("remote", 1'b0, remote_out);
        chk("keys", panel_keys_in, panel_keys_out);
        $display("test lockout done");
        ctl.put_byte(MTA);
        chk("talk", 1'b1, talk_out);
        ctl.pulse_ifc(4000);
        chk("talk", 1'b0, talk_out);
        chk("listen", 1'b0, listen_out);
        $display("test ifc done");
        setup_function_in <= 4'h5;
        setup_delay_in <= 16'h0042;
        repeat (2) @(posedge ref_clk_in);
        chk("function", 4'h3, cfg_function_out);
        ctl.put_byte(CMD_DCL);
        chk("clears", 1, clr_seen);
        chk("function", 4'h5, cfg_function_out);
        chk("delay", 16'h0042, cfg_delay_out);
        chk("bus_addr", ADDR_DEF, bus_addr_out);
        ctl.put_byte(CMD_SDC);
        chk("clears", 1, clr_seen);
        ctl.put_byte(MLA);
        ctl.put_byte(CMD_SDC);
        chk("clears", 2, clr_seen);
        chk("bus_addr", ADDR_DEF, bus_addr_out);
        chk("trigger", TRIG_DEF, cfg_trigger_out);
        $display("test clears done");
        // panel reset and address set are ignored while remote
        setup_function_in <= 4'h6;
        addr_value_in <= 5'h0C;
        pulse_panel(1'b1, 1'b1);
        chk("clears", 2, clr_seen);
        chk("function", 4'h5, cfg_function_out);
        chk("bus_addr", ADDR_DEF, bus_addr_out);
        press_local();
        pulse_panel(1'b0, 1'b1);
        chk("bus_addr", 5'h0C, bus_addr_out);
        pulse_panel(1'b1, 1'b0);
        chk("clears", 3, clr_seen);
        chk("function", 4'h6, cfg_function_out);
        chk("bus_addr", 5'h0C, bus_addr_out);
        ctl.put_byte(CMD_DCL);
        chk("clears", 4, clr_seen);
        chk("bus_addr", 5'h0C, bus_addr_out);
        $display("test panel done");
        give_verdict();
    end
endmodule
